/* File: erfs_pkg.sv */
// Constants, register map and field layout for the receive frame status filter
`default_nettype none
package erfs_pkg;
	// ****************************************
	// Register indices and byte address width
	// ****************************************
	localparam logic [11:0] IDX_ERR_FLAGS = 12'h156;
	localparam logic [11:0] IDX_STAT_FLAGS = 12'h157;
	localparam logic [11:0] IDX_MAX_LOW = 12'h158;
	localparam logic [11:0] IDX_MAX_HIGH = 12'h159;
	localparam logic [11:0] IDX_LOW_WM = 12'h15a;
	localparam logic [11:0] IDX_HIGH_WM = 12'h15b;
	localparam logic [11:0] IDX_IRQ_EN = 12'h15c;
	localparam logic [11:0] IDX_LATCHED = 12'h15d;
	localparam logic [11:0] IDX_REJECT = 12'h15e;
	localparam int ADDR_W = 14;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_MAX_LOW = 8'he0;
	localparam logic [7:0] RST_MAX_HIGH = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// ****************************************
	// Error flag byte bit positions
	// ****************************************
	localparam int EB_BAD_CHECK = 5;
	localparam int EB_ODD_BITS = 4;
	localparam int EB_PHY_ERR = 3;
	localparam int EB_OVERSIZE_TYPE = 2;
	localparam int EB_LATE_HIT = 1;
	localparam int EB_OVERLONG = 0;
	// ****************************************
	// Status flag byte bit positions
	// ****************************************
	localparam int SB_MISSED = 7;
	localparam int SB_BCAST = 4;
	localparam int SB_MCAST = 3;
	localparam int SB_BAD_OPCODE = 2;
	localparam int SB_CTRL = 1;
	localparam int SB_SIZE_MISMATCH = 0;
	// ****************************************
	// Interrupt enable and latched status positions
	// ****************************************
	localparam int IE_FIFO_OVF = 3;
	localparam int IE_QUEUE_OVF = 2;
	localparam int IE_LOW_MARK = 1;
	localparam int IE_HIGH_MARK = 0;
	localparam int LS_FIFO_OVF = 3;
	localparam int LS_QUEUE_OVF = 2;
	localparam int LS_HIGH_MARK = 1;
	localparam int LS_LOW_MARK = 0;
	// ****************************************
	// Reject control bit positions
	// ****************************************
	localparam int RC_OTHER_CTRL = 6;
	localparam int RC_CTRL = 5;
	localparam int RC_SIZE_MISMATCH = 4;
	localparam int RC_BAD_CHECK = 3;
	localparam int RC_ODD_BITS = 2;
	localparam int RC_PHY_ERR = 1;
	localparam int RC_BCAST = 0;
	// ****************************************
	// Frame constants
	// ****************************************
	localparam logic [15:0] STD_MAX_BYTES = 16'd1518;
	localparam logic [15:0] TYPE_MIN_BYTES = 16'd1536;
	localparam logic [15:0] COLL_WINDOW = 16'd64;
	localparam logic [15:0] MAX_LEN_FIELD = 16'd1500;
	localparam logic [15:0] MIN_PAYLOAD = 16'd46;
	localparam logic [15:0] FRAME_OVERHEAD = 16'd18;
	localparam logic [15:0] CTRL_ETHERTYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam logic [31:0] CHECK_POLY = 32'hedb88320;
	localparam logic [31:0] CHECK_INIT = 32'hffffffff;
	localparam logic [31:0] CHECK_RESIDUE = 32'hdebb20e3;
	// ****************************************
	// Watermark scaling: 32 packets of 2048 bytes
	// ****************************************
	localparam int WM_PACKETS = 32;
	localparam int WM_PKT_BYTES = 2048;
	localparam int WM_SHIFT = $clog2(WM_PACKETS * WM_PKT_BYTES);
	localparam int LEVEL_W = 8 + WM_SHIFT;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BUSY = 2'b10
	} erfs_rx_state_type;
endpackage
`default_nettype wire

/* File: erfs_top.sv */
// Receive frame status, size limit, reject control and queue watermark block
//
// The APB slave port is this design's own decision.
`default_nettype none
module erfs_top
	import erfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic rx_start_in,
	input wire logic rx_byte_valid_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_end_in,
	input wire logic rx_dribble_in,
	input wire logic rx_phy_err_in,
	input wire logic rx_col_in,
	input wire logic full_duplex_in,
	input wire logic pkt_missed_in,
	input wire logic fifo_ovf_in,
	input wire logic queue_ovf_in,
	input wire logic [LEVEL_W-1:0] queue_level_in,
	output logic frame_done_out,
	output logic frame_accept_out,
	output logic pause_tx_out,
	output logic rx_irq_out
);
	// ****************************************
	// Check value update, one byte
	// ****************************************
	function automatic logic [31:0] check_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CHECK_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] err_flags_r;
	logic [7:0] err_flags_nxt;
	logic [7:0] stat_flags_r;
	logic [7:0] stat_flags_nxt;
	logic [7:0] max_low_r;
	logic [7:0] max_high_r;
	logic [7:0] low_wm_r;
	logic [7:0] high_wm_r;
	logic [3:0] irq_en_r;
	logic [3:0] latched_r;
	logic [3:0] latched_nxt;
	logic [6:0] reject_r;
	logic [31:0] prdata_r;
	logic [3:0] read_clear_r;

	wire setup_ph = psel_in & ~penable_in;
	wire access_ph = psel_in & penable_in;
	wire [11:0] reg_idx = paddr_in[ADDR_W-1:2];
	wire aligned = (paddr_in[1:0] == 2'b00);
	wire hit_err = aligned & (reg_idx == IDX_ERR_FLAGS);
	wire hit_stat = aligned & (reg_idx == IDX_STAT_FLAGS);
	wire hit_max_low = aligned & (reg_idx == IDX_MAX_LOW);
	wire hit_max_high = aligned & (reg_idx == IDX_MAX_HIGH);
	wire hit_low_wm = aligned & (reg_idx == IDX_LOW_WM);
	wire hit_high_wm = aligned & (reg_idx == IDX_HIGH_WM);
	wire hit_irq_en = aligned & (reg_idx == IDX_IRQ_EN);
	wire hit_latched = aligned & (reg_idx == IDX_LATCHED);
	wire hit_reject = aligned & (reg_idx == IDX_REJECT);
	wire mapped = hit_err | hit_stat | hit_max_low | hit_max_high | hit_low_wm |
		hit_high_wm | hit_irq_en | hit_latched | hit_reject;
	wire wr_ok = access_ph & pwrite_in & mapped & pstrb_in[0];
	wire rd_latched = access_ph & ~pwrite_in & hit_latched;

	wire [7:0] rd_byte =
		hit_err ? err_flags_r :
		hit_stat ? stat_flags_r :
		hit_max_low ? max_low_r :
		hit_max_high ? max_high_r :
		hit_low_wm ? low_wm_r :
		hit_high_wm ? high_wm_r :
		hit_irq_en ? {4'h0, irq_en_r} :
		hit_latched ? {4'h0, latched_r} :
		hit_reject ? {1'b0, reject_r} : 8'h00;

	assign pready_out = access_ph;
	assign pslverr_out = access_ph & ~mapped;
	assign prdata_out = prdata_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prdata_r <= 32'h00000000;
			read_clear_r <= 4'h0;
		end else if (setup_ph) begin
			prdata_r <= {24'h000000, rd_byte};
			read_clear_r <= latched_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			max_low_r <= RST_MAX_LOW;
			max_high_r <= RST_MAX_HIGH;
			low_wm_r <= RST_ZERO;
			high_wm_r <= RST_ZERO;
			irq_en_r <= RST_ZERO[3:0];
			reject_r <= RST_ZERO[6:0];
		end else if (wr_ok) begin
			if (hit_max_low) max_low_r <= pwdata_in[7:0];
			if (hit_max_high) max_high_r <= pwdata_in[7:0];
			if (hit_low_wm) low_wm_r <= pwdata_in[7:0];
			if (hit_high_wm) high_wm_r <= pwdata_in[7:0];
			if (hit_irq_en) irq_en_r <= pwdata_in[3:0];
			if (hit_reject) reject_r <= pwdata_in[6:0];
		end
	end

	// ****************************************
	// Frame reception tracking
	// ****************************************
	erfs_rx_state_type state_r;
	erfs_rx_state_type state_nxt;
	logic [15:0] count_r;
	logic [31:0] check_r;
	logic bcast_run_r;
	logic mcast_r;
	logic [15:0] type_r;
	logic [15:0] opcode_r;
	logic phy_err_r;
	logic late_col_r;
	logic any_col_r;

	wire in_frame = (state_r == RX_BUSY);
	wire take_byte = in_frame & rx_byte_valid_in;
	wire [15:0] count_inc = (count_r == 16'hffff) ? count_r : count_r + 16'd1;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RX_IDLE: begin
				if (rx_start_in) state_nxt = RX_BUSY;
			end
			RX_BUSY: begin
				if (rx_end_in) state_nxt = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_r <= RX_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in | (rx_start_in & ~in_frame)) begin
			count_r <= 16'h0000;
			check_r <= CHECK_INIT;
			bcast_run_r <= 1'b1;
			mcast_r <= 1'b0;
			type_r <= 16'h0000;
			opcode_r <= 16'h0000;
		end else if (take_byte) begin
			count_r <= count_inc;
			check_r <= check_step(check_r, rx_byte_in);
			if (count_r < 16'd6) bcast_run_r <= bcast_run_r & (rx_byte_in == 8'hff);
			if (count_r == 16'd0) mcast_r <= rx_byte_in[0];
			if (count_r == 16'd12) type_r[15:8] <= rx_byte_in;
			if (count_r == 16'd13) type_r[7:0] <= rx_byte_in;
			if (count_r == 16'd14) opcode_r[15:8] <= rx_byte_in;
			if (count_r == 16'd15) opcode_r[7:0] <= rx_byte_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in | (rx_start_in & ~in_frame)) begin
			phy_err_r <= 1'b0;
			late_col_r <= 1'b0;
			any_col_r <= 1'b0;
		end else if (in_frame) begin
			if (rx_phy_err_in) phy_err_r <= 1'b1;
			if (rx_col_in) any_col_r <= 1'b1;
			if (rx_col_in & (count_r >= COLL_WINDOW)) late_col_r <= 1'b1;
		end
	end

	// ****************************************
	// Frame classification at frame end
	// ****************************************
	wire frame_end = in_frame & rx_end_in;
	wire [15:0] max_size = {max_high_r, max_low_r};
	wire runt = (count_r < COLL_WINDOW) | (any_col_r & ~late_col_r);
	wire is_8023 = (type_r <= MAX_LEN_FIELD);
	wire bad_check = (check_r != CHECK_RESIDUE);
	wire odd_bits = rx_dribble_in;
	wire oversize_type = (count_r > TYPE_MIN_BYTES) & ~is_8023;
	wire overlong = (count_r > STD_MAX_BYTES);
	wire bcast = bcast_run_r & (count_r >= 16'd6);
	wire mcast = mcast_r & ~bcast;
	wire ctrl = (type_r == CTRL_ETHERTYPE) & full_duplex_in;
	wire bad_opcode = (type_r == CTRL_ETHERTYPE) & (opcode_r != PAUSE_OPCODE);
	wire is_pause = ctrl & ~bad_opcode;
	wire [15:0] payload = count_r - FRAME_OVERHEAD;
	wire size_mismatch = is_8023 & ((type_r >= MIN_PAYLOAD) ? (payload != type_r) :
		(count_r != COLL_WINDOW));
	wire odd_counts = odd_bits & ~runt & ~any_col_r;

	wire rej_size = (count_r > max_size);
	wire rej_ctrl = ctrl & ~reject_r[RC_CTRL];
	wire rej_other = ctrl & ~is_pause & ~reject_r[RC_OTHER_CTRL];
	wire rej_mismatch = size_mismatch & ~reject_r[RC_SIZE_MISMATCH];
	wire rej_check = (bad_check | phy_err_r) & ~reject_r[RC_BAD_CHECK];
	wire rej_phy = phy_err_r & ~reject_r[RC_PHY_ERR];
	wire rej_odd = odd_counts & ~reject_r[RC_ODD_BITS];
	wire rej_bcast = bcast & ~reject_r[RC_BCAST];
	wire reject = rej_size | rej_ctrl | rej_other | rej_mismatch | rej_check |
		rej_phy | rej_odd | rej_bcast;

	always_comb begin
		err_flags_nxt = err_flags_r;
		if (frame_end) begin
			err_flags_nxt = 8'h00;
			err_flags_nxt[EB_BAD_CHECK] = bad_check;
			err_flags_nxt[EB_ODD_BITS] = odd_bits;
			err_flags_nxt[EB_PHY_ERR] = phy_err_r;
			err_flags_nxt[EB_OVERSIZE_TYPE] = oversize_type;
			err_flags_nxt[EB_LATE_HIT] = late_col_r;
			err_flags_nxt[EB_OVERLONG] = overlong;
		end
	end

	always_comb begin
		stat_flags_nxt = stat_flags_r;
		if (frame_end) begin
			stat_flags_nxt[SB_BCAST] = bcast;
			stat_flags_nxt[SB_MCAST] = mcast;
			stat_flags_nxt[SB_BAD_OPCODE] = bad_opcode;
			stat_flags_nxt[SB_CTRL] = ctrl;
			stat_flags_nxt[SB_SIZE_MISMATCH] = size_mismatch;
		end
		if (rx_start_in & ~in_frame) stat_flags_nxt[SB_MISSED] = 1'b0;
		if (pkt_missed_in) stat_flags_nxt[SB_MISSED] = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			err_flags_r <= RST_ZERO;
			stat_flags_r <= RST_ZERO;
			frame_done_out <= 1'b0;
			frame_accept_out <= 1'b0;
			pause_tx_out <= 1'b0;
		end else begin
			err_flags_r <= err_flags_nxt;
			stat_flags_r <= stat_flags_nxt;
			frame_done_out <= frame_end;
			frame_accept_out <= frame_end & ~reject;
			pause_tx_out <= frame_end & is_pause & ~reject;
		end
	end

	// ****************************************
	// Queue watermarks and latched events
	// ****************************************
	logic [LEVEL_W-1:0] level_prev_r;
	wire [LEVEL_W-1:0] low_thr = {low_wm_r, {WM_SHIFT{1'b0}}};
	wire [LEVEL_W-1:0] high_thr = {high_wm_r, {WM_SHIFT{1'b0}}};
	wire high_cross = (level_prev_r < high_thr) & (queue_level_in >= high_thr);
	wire low_cross = (level_prev_r >= low_thr) & (queue_level_in < low_thr);

	always_comb begin
		latched_nxt = latched_r;
		if (rd_latched) latched_nxt = latched_r & ~read_clear_r;
		if (fifo_ovf_in) latched_nxt[LS_FIFO_OVF] = 1'b1;
		if (queue_ovf_in) latched_nxt[LS_QUEUE_OVF] = 1'b1;
		if (high_cross) latched_nxt[LS_HIGH_MARK] = 1'b1;
		if (low_cross) latched_nxt[LS_LOW_MARK] = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			level_prev_r <= {LEVEL_W{1'b0}};
			latched_r <= RST_ZERO[3:0];
			rx_irq_out <= 1'b0;
		end else begin
			level_prev_r <= queue_level_in;
			latched_r <= latched_nxt;
			rx_irq_out <= (latched_r[LS_FIFO_OVF] & irq_en_r[IE_FIFO_OVF]) |
				(latched_r[LS_QUEUE_OVF] & irq_en_r[IE_QUEUE_OVF]) |
				(latched_r[LS_LOW_MARK] & irq_en_r[IE_LOW_MARK]) |
				(latched_r[LS_HIGH_MARK] & irq_en_r[IE_HIGH_MARK]);
		end
	end
endmodule
`default_nettype wire

/* File: erfs_assertions.sv */
// Port checker for the receive frame status filter
`default_nettype none
module erfs_assertions
	import erfs_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic pslverr_out,
	input wire logic rx_start_in,
	input wire logic rx_byte_valid_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_end_in,
	input wire logic rx_dribble_in,
	input wire logic rx_phy_err_in,
	input wire logic rx_col_in,
	input wire logic full_duplex_in,
	input wire logic fifo_ovf_in,
	input wire logic queue_ovf_in,
	input wire logic [LEVEL_W-1:0] queue_level_in,
	input wire logic frame_done_out,
	input wire logic frame_accept_out,
	input wire logic pause_tx_out,
	input wire logic rx_irq_out
);
	// ****
	// Frame and register shadows
	// ****
	logic busy_r, phy_r, col_r;
	logic [15:0] cnt_r, typ_r, max_r;
	logic [7:0] rej_r;
	logic [3:0] ev_r;
	logic [LEVEL_W-1:0] lvl_r;
	wire [11:0] idx = paddr_in[13:2];
	wire bad_a = paddr_in[1:0] != 2'b00 || idx < IDX_ERR_FLAGS || idx > IDX_REJECT;
	wire wr_ok = psel_in && penable_in && pwrite_in && pstrb_in[0] && !bad_a;
	wire byte_ok = busy_r && rx_byte_valid_in;
	wire cause = fifo_ovf_in || queue_ovf_in || queue_level_in != lvl_r || wr_ok;
	wire done_ctrl = frame_done_out && typ_r == CTRL_ETHERTYPE && full_duplex_in;
	always_ff @(posedge clk_in) begin
		lvl_r <= queue_level_in;
		if (srst_in) begin
			{busy_r, phy_r, col_r, ev_r, rej_r} <= '0;
			max_r <= {RST_MAX_HIGH, RST_MAX_LOW};
		end else begin
			ev_r <= {ev_r[2:0], cause};
			if (rx_start_in && !busy_r) begin
				busy_r <= 1'b1;
				{cnt_r, phy_r, col_r} <= '0;
			end
			if (rx_end_in)
				busy_r <= 1'b0;
			if (byte_ok)
				cnt_r <= cnt_r + 16'h0001;
			if (byte_ok && cnt_r == 16'h000c)
				typ_r[15:8] <= rx_byte_in;
			if (byte_ok && cnt_r == 16'h000d)
				typ_r[7:0] <= rx_byte_in;
			if (busy_r)
				{phy_r, col_r} <= {phy_r | rx_phy_err_in, col_r | rx_col_in};
			if (wr_ok && idx == IDX_MAX_LOW)
				max_r[7:0] <= pwdata_in[7:0];
			if (wr_ok && idx == IDX_MAX_HIGH)
				max_r[15:8] <= pwdata_in[7:0];
			if (wr_ok && idx == IDX_REJECT)
				rej_r <= pwdata_in[7:0];
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	property p_done;
		rx_end_in && busy_r |=> frame_done_out;
	endproperty
	a_done: assert property (p_done) else $error("frame end not reported");
	property p_acc;
		frame_accept_out |-> frame_done_out && $past(rx_end_in);
	endproperty
	a_acc: assert property (p_acc) else $error("accept outside frame end");
	property p_max;
		frame_done_out && cnt_r > max_r |-> !frame_accept_out;
	endproperty
	a_max: assert property (p_max) else $error("oversize frame accepted");
	property p_pause;
		pause_tx_out |-> frame_accept_out && done_ctrl;
	endproperty
	a_pause: assert property (p_pause) else $error("pause without control frame");
	property p_phy;
		frame_done_out && phy_r && !rej_r[RC_PHY_ERR] |-> !frame_accept_out;
	endproperty
	a_phy: assert property (p_phy) else $error("phy error frame accepted");
	property p_odd;
		frame_done_out && $past(rx_dribble_in) && !col_r && cnt_r >= 16'd64
			&& !rej_r[RC_ODD_BITS] |-> !frame_accept_out;
	endproperty
	a_odd: assert property (p_odd) else $error("odd bit frame accepted");
	property p_ctrl;
		done_ctrl && !rej_r[RC_CTRL] |-> !frame_accept_out;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control frame accepted");
	property p_irq;
		$rose(rx_irq_out) |-> ev_r != 4'h0;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without event");
	property p_err;
		psel_in && penable_in |-> pslverr_out == bad_a;
	endproperty
	a_err: assert property (p_err) else $error("bus error mismatch");
	c_acc: cover property (frame_accept_out);
	c_rej: cover property (frame_done_out && !frame_accept_out);
	c_pause: cover property (pause_tx_out);
	c_irq: cover property ($rose(rx_irq_out));
endmodule
bind erfs_top erfs_assertions u_chk (.*);
`default_nettype wire

/* File: erfs_phy_model.sv */
// Behavioural receive frame source on the PHY side
`default_nettype none
module erfs_phy_model
	import erfs_pkg::*;
(
	input wire logic clk_in,
	output logic start_out,
	output logic valid_out,
	output logic [7:0] byte_out,
	output logic end_out,
	output logic dribble_out,
	output logic phy_err_out,
	output logic col_out
);
	// ****
	// Frame sender with trailing check value
	// ****
	initial begin
		{start_out, valid_out, end_out, dribble_out, phy_err_out, col_out} = '0;
		byte_out = 8'h55;
	end
	task automatic send(input logic [7:0] da, input logic [15:0] typ, input logic [15:0] op,
		input int n, input logic bad, input logic drib, input logic perr, input int col);
		logic [31:0] crc;
		logic [31:0] fcs;
		logic [7:0] b;
		crc = CHECK_INIT;
		fcs = '0;
		@(posedge clk_in);
		start_out <= 1'b1;
		for (int i = 0; i < n; i++) begin
			b = i < 6 ? da : i < 12 ? 8'h02 : i == 12 ? typ[15:8] : i == 13 ? typ[7:0] :
				i == 14 ? op[15:8] : i == 15 ? op[7:0] : i[7:0];
			if (i == n - 4)
				fcs = ~crc ^ {31'h0, bad};
			if (i >= n - 4)
				b = fcs[8 * (i - n + 4) +: 8];
			crc = crc ^ {24'h0, b};
			for (int k = 0; k < 8; k++)
				crc = crc[0] ? (crc >> 1) ^ CHECK_POLY : crc >> 1;
			@(posedge clk_in);
			start_out <= 1'b0;
			valid_out <= 1'b1;
			byte_out <= b;
			phy_err_out <= perr && i == 20;
			col_out <= i == col;
		end
		@(posedge clk_in);
		{valid_out, phy_err_out, col_out} <= '0;
		byte_out <= ~byte_out;
		end_out <= 1'b1;
		dribble_out <= drib;
		@(posedge clk_in);
		{end_out, dribble_out} <= '0;
		byte_out <= ~byte_out;
	endtask
endmodule
`default_nettype wire

/* File: test_erfs_top.sv */
// Self-checking bench for the receive frame status filter
`default_nettype none
module test_erfs_top
	import erfs_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench signals, tasks and sequence
	// ****
	logic clk_in, srst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
	logic [ADDR_W-1:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic [3:0] pstrb_in;
	logic rx_start_in, rx_byte_valid_in, rx_end_in, rx_dribble_in, rx_phy_err_in, rx_col_in;
	logic [7:0] rx_byte_in;
	logic full_duplex_in, pkt_missed_in, fifo_ovf_in, queue_ovf_in;
	logic [LEVEL_W-1:0] queue_level_in;
	logic frame_done_out, frame_accept_out, pause_tx_out, rx_irq_out;
	logic [7:0] rst [9] = '{8'h00, 8'h00, 8'he0, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int failures = 0;
	int checked = 0;
	erfs_top u_dut (.*);
	erfs_phy_model u_phy (.clk_in(clk_in), .start_out(rx_start_in),
		.valid_out(rx_byte_valid_in), .byte_out(rx_byte_in), .end_out(rx_end_in),
		.dribble_out(rx_dribble_in), .phy_err_out(rx_phy_err_in), .col_out(rx_col_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge clk_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do
			@(posedge clk_in);
		while (pready_out !== 1'b1);
		{rd, er} = {prdata_out, pslverr_out};
		{psel_in, penable_in} <= 2'b00;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		apb(1'b1, {idx, 2'b00}, {24'h0, d});
	endtask
	task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, {idx, 2'b00}, 32'h0);
		chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
	endtask
	task automatic frm(input logic [7:0] da, input logic [15:0] typ, input logic [15:0] op,
		input int n, input logic [2:0] f, input int col, input logic [1:0] ea,
		input logic [7:0] ee, input logic [7:0] es);
		u_phy.send(da, typ, op, n, f[2], f[1], f[0], col);
		do
			@(posedge clk_in);
		while (frame_done_out !== 1'b1);
		chk("pause accept", {30'h0, ea}, {30'h0, pause_tx_out, frame_accept_out});
		rdc(IDX_ERR_FLAGS, ee);
		rdc(IDX_STAT_FLAGS, es);
	endtask
	initial begin
		{psel_in, penable_in, pwrite_in, full_duplex_in, pkt_missed_in} = '0;
		{fifo_ovf_in, queue_ovf_in, paddr_in, pwdata_in, queue_level_in} = '0;
		pstrb_in = 4'hf;
		srst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		foreach (rst[i])
			rdc(IDX_ERR_FLAGS + 12'(i), rst[i]);
		wr(IDX_STAT_FLAGS, 8'hff);
		rdc(IDX_STAT_FLAGS, 8'h00);
		apb(1'b0, 14'h057c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, 14'h0561, 32'h5);
		rdc(IDX_MAX_LOW, 8'he0);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b000, -1, 2'b01, 8'h00, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b100, -1, 2'b00, 8'h20, 8'h00);
		wr(IDX_REJECT, 8'h08);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b100, -1, 2'b01, 8'h20, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b001, -1, 2'b00, 8'h08, 8'h00);
		wr(IDX_REJECT, 8'h0a);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b001, -1, 2'b01, 8'h08, 8'h00);
		wr(IDX_REJECT, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 64, 3'b010, -1, 2'b00, 8'h10, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 100, 3'b000, 70, 2'b01, 8'h02, 8'h00);
		frm(8'hff, 16'h0800, 16'h0, 64, 3'b000, -1, 2'b00, 8'h00, 8'h10);
		frm(8'h01, 16'h0800, 16'h0, 64, 3'b000, -1, 2'b01, 8'h00, 8'h08);
		frm(8'h02, 16'h0800, 16'h0, 1540, 3'b000, -1, 2'b01, 8'h05, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 1519, 3'b000, -1, 2'b01, 8'h01, 8'h00);
		frm(8'h02, 16'd46, 16'h0, 64, 3'b000, -1, 2'b01, 8'h00, 8'h00);
		frm(8'h02, 16'd50, 16'h0, 64, 3'b000, -1, 2'b00, 8'h00, 8'h01);
		wr(IDX_REJECT, 8'h15);
		frm(8'h02, 16'd50, 16'h0, 64, 3'b010, -1, 2'b01, 8'h10, 8'h01);
		frm(8'hff, 16'h0800, 16'h0, 64, 3'b000, -1, 2'b01, 8'h00, 8'h10);
		wr(IDX_MAX_LOW, 8'h64);
		wr(IDX_MAX_HIGH, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 101, 3'b000, -1, 2'b00, 8'h00, 8'h00);
		frm(8'h02, 16'h0800, 16'h0, 100, 3'b000, -1, 2'b01, 8'h00, 8'h00);
		frm(8'h02, 16'h8808, 16'h2, 64, 3'b000, -1, 2'b01, 8'h00, 8'h04);
		full_duplex_in <= 1'b1;
		wr(IDX_REJECT, 8'h00);
		frm(8'h02, 16'h8808, 16'h1, 64, 3'b000, -1, 2'b00, 8'h00, 8'h02);
		wr(IDX_REJECT, 8'h20);
		frm(8'h02, 16'h8808, 16'h1, 64, 3'b000, -1, 2'b11, 8'h00, 8'h02);
		frm(8'h02, 16'h8808, 16'h2, 64, 3'b000, -1, 2'b00, 8'h00, 8'h06);
		wr(IDX_REJECT, 8'h60);
		frm(8'h02, 16'h8808, 16'h2, 64, 3'b000, -1, 2'b01, 8'h00, 8'h06);
		pkt_missed_in <= 1'b1;
		@(posedge clk_in);
		pkt_missed_in <= 1'b0;
		rdc(IDX_STAT_FLAGS, 8'h86);
		wr(IDX_HIGH_WM, 8'h01);
		wr(IDX_LOW_WM, 8'h01);
		wr(IDX_IRQ_EN, 8'h01);
		queue_level_in <= 24'h00ffff;
		rdc(IDX_LATCHED, 8'h00);
		queue_level_in <= 24'h010000;
		repeat (3) @(posedge clk_in);
		chk("irq", 32'h1, {31'h0, rx_irq_out});
		rdc(IDX_LATCHED, 8'h02);
		rdc(IDX_LATCHED, 8'h00);
		queue_level_in <= 24'h00ffff;
		repeat (3) @(posedge clk_in);
		chk("irq", 32'h0, {31'h0, rx_irq_out});
		rdc(IDX_LATCHED, 8'h01);
		wr(IDX_IRQ_EN, 8'h08);
		fifo_ovf_in <= 1'b1;
		@(posedge clk_in);
		{fifo_ovf_in, queue_ovf_in} <= 2'b01;
		@(posedge clk_in);
		queue_ovf_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("irq", 32'h1, {31'h0, rx_irq_out});
		rdc(IDX_LATCHED, 8'h0c);
		repeat (2) @(posedge clk_in);
		chk("irq", 32'h0, {31'h0, rx_irq_out});
		wr(IDX_IRQ_EN, 8'h06);
		queue_ovf_in <= 1'b1;
		@(posedge clk_in);
		queue_ovf_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("irq", 32'h1, {31'h0, rx_irq_out});
		rdc(IDX_LATCHED, 8'h04);
		queue_level_in <= 24'h010000;
		@(posedge clk_in);
		queue_level_in <= 24'h00ffff;
		repeat (3) @(posedge clk_in);
		chk("irq", 32'h1, {31'h0, rx_irq_out});
		rdc(IDX_LATCHED, 8'h03);
		results();
	end
	initial begin
		#3000000;
		failures++;
		results();
	end
endmodule
`default_nettype wire
